// File: pkg/csfp_pkg.sv
// Constants and types for the socket force-event and socket control registers
package csfp_pkg;

  // Register bus geometry
  localparam int CSFP_ADDR_W = 12;
  localparam int CSFP_DATA_W = 32;

  // Register byte offsets
  localparam logic [CSFP_ADDR_W-1:0] CSFP_OFS_FORCE = 12'h00c;
  localparam logic [CSFP_ADDR_W-1:0] CSFP_OFS_CTRL = 12'h010;

  // Force-event register field positions
  localparam int CSFP_FRC_SENSE_BIT = 14;
  localparam int CSFP_FRC_STATE_HI = 13;
  localparam int CSFP_FRC_STATE_LO = 7;
  localparam int CSFP_FRC_WIDE_BIT = 5;
  localparam int CSFP_FRC_NARROW_BIT = 4;
  localparam int CSFP_FRC_PWR_BIT = 3;
  localparam int CSFP_FRC_DET2_BIT = 2;
  localparam int CSFP_FRC_DET1_BIT = 1;
  localparam int CSFP_FRC_STAT_BIT = 0;
  localparam int CSFP_STATE_W = CSFP_FRC_STATE_HI - CSFP_FRC_STATE_LO + 1;

  // Socket control register field positions
  localparam int CSFP_CTL_STOP_BIT = 7;
  localparam int CSFP_CTL_VCC_HI = 6;
  localparam int CSFP_CTL_VCC_LO = 4;
  localparam int CSFP_CTL_VPP_HI = 2;
  localparam int CSFP_CTL_VPP_LO = 0;
  localparam int CSFP_SUP_W = 3;
  localparam int CSFP_LEG_W = 2;

  // Reset values
  localparam logic CSFP_STOP_RST = 1'b0;
  localparam logic [CSFP_SUP_W-1:0] CSFP_SUP_RST = 3'h0;
  localparam logic [CSFP_DATA_W-1:0] CSFP_RDATA_RST = 32'h0000_0000;

  // Decoded supply voltages
  typedef enum logic [2:0]
  {
    CSFP_V_OFF = 3'b000,
    CSFP_V_12 = 3'b001,
    CSFP_V_5 = 3'b010,
    CSFP_V_3P3 = 3'b011,
    CSFP_V_X = 3'b100,
    CSFP_V_Y = 3'b101,
    CSFP_V_RSVD = 3'b111
  } csfp_volt_e;

endpackage

// File: rtl/csfp_supply_watch.sv
// Change watcher for one supply select field
`timescale 1ns/10ps
module csfp_supply_watch #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Watched field
  input wire logic [W-1:0] value,
  // One-cycle pulse after any change
  output logic changed
);

  logic [W-1:0] prev_ff;
  logic changed_ff;

  // Previous value starts at the reset code so no spurious start
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      prev_ff <= '0;
    else
      prev_ff <= value;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      changed_ff <= 1'b0;
    else
      changed_ff <= (value != prev_ff);
  end

  assign changed = changed_ff;

endmodule

// File: rtl/csfp_top.sv
// Socket force-event and socket control registers with supply select
//
// Contract
// - Reserved bits of both registers are written as zero and read back as zero.
// - Writing one to bit 14 of the force-event register restarts voltage sensing.
// - Bits 13 to 7 written to the force-event register are copied to the state flags.
// - Bits 5 and 4 set the card type flags, but are ignored while a card is present.
// - Bit 3 written as one sets the power-cycle event, leaving power status alone.
// - Bits 2 and 1 written as one set the detect-two and detect-one events.
// - Bit 0 written as one sets the status-change event, leaving its line flag alone.
// - Control bit 7 allows socket clock stopping when one and resets to zero.
// - Card supply field 6:4 decodes off, 5 V, 3.3 V, X.X V, Y.Y V; others reserved.
// - Programming supply field 2:0 decodes off, 12 V, 5 V, 3.3 V, X.X V, Y.Y V.
// - Legacy power control accesses share storage with the supply select fields.
// - Force-event fields are write-only; only reserved bits are readable, as zero.
// - Any change of a supply select starts the serial power-switch update.
`timescale 1ns/10ps
module csfp_top
  import csfp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [csfp_pkg::CSFP_ADDR_W-1:0] reg_addr,
  input wire logic [csfp_pkg::CSFP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [csfp_pkg::CSFP_DATA_W-1:0] reg_rdata,
  // Legacy power control view
  input wire logic legacy_power_control_wr,
  input wire logic [csfp_pkg::CSFP_LEG_W-1:0] legacy_vcc_wdata,
  input wire logic [csfp_pkg::CSFP_LEG_W-1:0] legacy_vpp_wdata,
  output logic [csfp_pkg::CSFP_LEG_W-1:0] legacy_vcc_rdata,
  output logic [csfp_pkg::CSFP_LEG_W-1:0] legacy_vpp_rdata,
  // Socket status from the present-state logic
  input wire logic card_present,
  // Present-state overrides
  output logic state_force_wr,
  output logic [csfp_pkg::CSFP_STATE_W-1:0] state_force_val,
  output logic card_type_force_wr,
  output logic wide_bus_card_force,
  output logic narrow_bus_card_force,
  // Event flag sets
  output logic power_cycle_event_set,
  output logic detect_two_event_set,
  output logic detect_one_event_set,
  output logic status_change_event_set,
  // Sensing restart
  output logic sense_restart,
  // Socket control
  output logic clock_stop_allow,
  output logic [csfp_pkg::CSFP_SUP_W-1:0] card_supply_select,
  output logic [csfp_pkg::CSFP_SUP_W-1:0] program_supply_select,
  output csfp_pkg::csfp_volt_e card_volt,
  output csfp_pkg::csfp_volt_e program_volt,
  output logic power_update_start
);

  import csfp_pkg::*;

  default clocking dck @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  logic force_wr, ctrl_wr, ctrl_rd, stop_ff;
  logic [CSFP_SUP_W-1:0] vcc_ff, vpp_ff, nxt_vcc, nxt_vpp;
  logic [CSFP_DATA_W-1:0] rdata_ff, nxt_rdata;
  logic state_wr_ff, type_wr_ff, wide_ff, narrow_ff;
  logic [CSFP_STATE_W-1:0] state_val_ff;
  logic pwr_ev_ff, det2_ev_ff, det1_ev_ff, stat_ev_ff, sense_ff;
  csfp_volt_e card_volt_ff, prog_volt_ff;
  logic vcc_chg, vpp_chg, upd_start;

  // Address decode
  always_comb
  begin
    force_wr = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_rd = 1'b0;
    if (reg_addr == CSFP_OFS_FORCE)
      force_wr = reg_wr;
    else if (reg_addr == CSFP_OFS_CTRL)
    begin
      ctrl_wr = reg_wr;
      ctrl_rd = reg_rd;
    end
  end

  // Present-state overrides; card type is dropped while a card sits in the socket
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_wr_ff <= 1'b0;
      state_val_ff <= '0;
      type_wr_ff <= 1'b0;
      wide_ff <= 1'b0;
      narrow_ff <= 1'b0;
    end
    else
    begin
      state_wr_ff <= force_wr;
      if (force_wr)
        state_val_ff <= reg_wdata[CSFP_FRC_STATE_HI:CSFP_FRC_STATE_LO];
      type_wr_ff <= force_wr && !card_present;
      if (force_wr && !card_present)
      begin
        wide_ff <= reg_wdata[CSFP_FRC_WIDE_BIT];
        narrow_ff <= reg_wdata[CSFP_FRC_NARROW_BIT];
      end
    end
  end

  // Event sets and sensing restart: only ones act, zeros never clear or abort
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pwr_ev_ff <= 1'b0;
      det2_ev_ff <= 1'b0;
      det1_ev_ff <= 1'b0;
      stat_ev_ff <= 1'b0;
      sense_ff <= 1'b0;
    end
    else
    begin
      pwr_ev_ff <= force_wr && reg_wdata[CSFP_FRC_PWR_BIT];
      det2_ev_ff <= force_wr && reg_wdata[CSFP_FRC_DET2_BIT];
      det1_ev_ff <= force_wr && reg_wdata[CSFP_FRC_DET1_BIT];
      stat_ev_ff <= force_wr && reg_wdata[CSFP_FRC_STAT_BIT];
      sense_ff <= force_wr && reg_wdata[CSFP_FRC_SENSE_BIT];
    end
  end

  // Clock stop permission
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      stop_ff <= CSFP_STOP_RST;
    else if (ctrl_wr)
      stop_ff <= reg_wdata[CSFP_CTL_STOP_BIT];
  end

  // Shared supply storage; the full register write wins a same-cycle clash
  always_comb
  begin
    nxt_vcc = vcc_ff;
    nxt_vpp = vpp_ff;
    if (ctrl_wr)
    begin
      nxt_vcc = reg_wdata[CSFP_CTL_VCC_HI:CSFP_CTL_VCC_LO];
      nxt_vpp = reg_wdata[CSFP_CTL_VPP_HI:CSFP_CTL_VPP_LO];
    end
    else if (legacy_power_control_wr)
    begin
      nxt_vcc = {vcc_ff[CSFP_SUP_W-1], legacy_vcc_wdata};
      nxt_vpp = {vpp_ff[CSFP_SUP_W-1], legacy_vpp_wdata};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      vcc_ff <= CSFP_SUP_RST;
      vpp_ff <= CSFP_SUP_RST;
    end
    else
    begin
      vcc_ff <= nxt_vcc;
      vpp_ff <= nxt_vpp;
    end
  end

  // Supply decode, registered one cycle behind the select fields
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      card_volt_ff <= CSFP_V_OFF;
      prog_volt_ff <= CSFP_V_OFF;
    end
    else
    begin
      case (vcc_ff)
        3'h0: card_volt_ff <= CSFP_V_OFF;
        3'h2: card_volt_ff <= CSFP_V_5;
        3'h3: card_volt_ff <= CSFP_V_3P3;
        3'h4: card_volt_ff <= CSFP_V_X;
        3'h5: card_volt_ff <= CSFP_V_Y;
        default: card_volt_ff <= CSFP_V_RSVD;
      endcase
      case (vpp_ff)
        3'h0: prog_volt_ff <= CSFP_V_OFF;
        3'h1: prog_volt_ff <= CSFP_V_12;
        3'h2: prog_volt_ff <= CSFP_V_5;
        3'h3: prog_volt_ff <= CSFP_V_3P3;
        3'h4: prog_volt_ff <= CSFP_V_X;
        3'h5: prog_volt_ff <= CSFP_V_Y;
        default: prog_volt_ff <= CSFP_V_RSVD;
      endcase
    end
  end

  // Power-switch update trigger
  csfp_supply_watch #(
    .W(CSFP_SUP_W)
  ) u_vcc_watch (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .value(vcc_ff),
    .changed(vcc_chg)
  );

  csfp_supply_watch #(
    .W(CSFP_SUP_W)
  ) u_vpp_watch (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .value(vpp_ff),
    .changed(vpp_chg)
  );

  assign upd_start = vcc_chg || vpp_chg;

  // Read data; force register and unmapped space read zero
  always_comb
  begin
    nxt_rdata = CSFP_RDATA_RST;
    if (ctrl_rd)
    begin
      nxt_rdata[CSFP_CTL_STOP_BIT] = stop_ff;
      nxt_rdata[CSFP_CTL_VCC_HI:CSFP_CTL_VCC_LO] = vcc_ff;
      nxt_rdata[CSFP_CTL_VPP_HI:CSFP_CTL_VPP_LO] = vpp_ff;
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      rdata_ff <= CSFP_RDATA_RST;
    else
      rdata_ff <= nxt_rdata;
  end

  // Outputs
  assign reg_rdata = rdata_ff;
  assign legacy_vcc_rdata = vcc_ff[CSFP_LEG_W-1:0];
  assign legacy_vpp_rdata = vpp_ff[CSFP_LEG_W-1:0];
  assign state_force_wr = state_wr_ff;
  assign state_force_val = state_val_ff;
  assign card_type_force_wr = type_wr_ff;
  assign wide_bus_card_force = wide_ff;
  assign narrow_bus_card_force = narrow_ff;
  assign power_cycle_event_set = pwr_ev_ff;
  assign detect_two_event_set = det2_ev_ff;
  assign detect_one_event_set = det1_ev_ff;
  assign status_change_event_set = stat_ev_ff;
  assign sense_restart = sense_ff;
  assign clock_stop_allow = stop_ff;
  assign card_supply_select = vcc_ff;
  assign program_supply_select = vpp_ff;
  assign card_volt = card_volt_ff;
  assign program_volt = prog_volt_ff;
  assign power_update_start = upd_start;

  // Checks
  property p_ctrl_rsvd_zero;
    ctrl_rd |=> (reg_rdata[31:8] == 24'h00_0000) && !reg_rdata[3];
  endproperty
  a_ctrl_rsvd_zero: assert property (p_ctrl_rsvd_zero)
    else $error("control reserved bits read nonzero");
  property p_force_reads_zero;
    (reg_rd && reg_addr == CSFP_OFS_FORCE) |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("force register read nonzero");
  property p_sense_cause;
    sense_restart |-> $past(force_wr && reg_wdata[CSFP_FRC_SENSE_BIT]);
  endproperty
  a_sense_cause: assert property (p_sense_cause)
    else $error("sense restart without a one written");
  property p_state_copy;
    force_wr |=> state_force_wr
      && state_force_val == $past(reg_wdata[CSFP_FRC_STATE_HI:CSFP_FRC_STATE_LO]);
  endproperty
  a_state_copy: assert property (p_state_copy)
    else $error("state flags not copied");
  property p_type_blocked;
    (force_wr && card_present) |=> !card_type_force_wr;
  endproperty
  a_type_blocked: assert property (p_type_blocked)
    else $error("card type forced while card present");
  property p_power_event;
    (force_wr && reg_wdata[CSFP_FRC_PWR_BIT]) |=> power_cycle_event_set ##1 !power_cycle_event_set
      or (force_wr && reg_wdata[CSFP_FRC_PWR_BIT]);
  endproperty
  a_power_event: assert property (p_power_event)
    else $error("power cycle event not set");
  property p_detect_events;
    force_wr |=> detect_two_event_set == $past(reg_wdata[CSFP_FRC_DET2_BIT])
      && detect_one_event_set == $past(reg_wdata[CSFP_FRC_DET1_BIT]);
  endproperty
  a_detect_events: assert property (p_detect_events)
    else $error("detect events wrong");
  property p_status_event;
    status_change_event_set |-> $past(force_wr && reg_wdata[CSFP_FRC_STAT_BIT]);
  endproperty
  a_status_event: assert property (p_status_event)
    else $error("status change event without cause");
  property p_zero_no_effect;
    (force_wr && reg_wdata[3:0] == 4'h0 && !reg_wdata[CSFP_FRC_SENSE_BIT])
      |=> !power_cycle_event_set && !detect_two_event_set && !detect_one_event_set
      && !status_change_event_set && !sense_restart;
  endproperty
  a_zero_no_effect: assert property (p_zero_no_effect)
    else $error("zero write had an effect");
  property p_stop_write;
    ctrl_wr |=> clock_stop_allow == $past(reg_wdata[CSFP_CTL_STOP_BIT]);
  endproperty
  a_stop_write: assert property (p_stop_write)
    else $error("clock stop bit not written");
  property p_vcc_decode;
    (card_supply_select == 3'h3) ##1 (card_supply_select == 3'h3) |-> card_volt == CSFP_V_3P3;
  endproperty
  a_vcc_decode: assert property (p_vcc_decode)
    else $error("card supply decode wrong");
  property p_vpp_decode;
    (program_supply_select == 3'h1) ##1 (program_supply_select == 3'h1)
      |-> program_volt == CSFP_V_12;
  endproperty
  a_vpp_decode: assert property (p_vpp_decode)
    else $error("program supply decode wrong");
  property p_legacy_share;
    (legacy_power_control_wr && !ctrl_wr) |=> legacy_vcc_rdata == $past(legacy_vcc_wdata)
      && card_supply_select[2] == $past(card_supply_select[2]);
  endproperty
  a_legacy_share: assert property (p_legacy_share)
    else $error("legacy view out of step");
  // Watcher pulse follows the edge at which the new select is first seen
  property p_update_start;
    !$stable(card_supply_select) || !$stable(program_supply_select) |=> power_update_start;
  endproperty
  a_update_start: assert property (p_update_start)
    else $error("no power update after supply change");

  c_card_forced: cover property (force_wr && !card_present ##1 card_type_force_wr);
  c_type_ignored: cover property (force_wr && card_present && reg_wdata[CSFP_FRC_WIDE_BIT]);
  c_legacy_write: cover property (legacy_power_control_wr ##2 power_update_start);
  c_legacy_clash: cover property (legacy_power_control_wr && ctrl_wr);
  c_ctrl_readback: cover property (ctrl_wr ##1 ctrl_rd);

endmodule

// File: verif/csfp_top_tb.sv
// Self-checking bench for the socket force-event and socket control registers
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e); end end
module csfp_top_tb;
  import csfp_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [CSFP_ADDR_W-1:0] reg_addr = '0;
  logic [CSFP_DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [CSFP_DATA_W-1:0] reg_rdata;
  logic legacy_power_control_wr = 1'b0;
  logic [CSFP_LEG_W-1:0] legacy_vcc_wdata = '0;
  logic [CSFP_LEG_W-1:0] legacy_vpp_wdata = '0;
  logic [CSFP_LEG_W-1:0] legacy_vcc_rdata;
  logic [CSFP_LEG_W-1:0] legacy_vpp_rdata;
  logic card_present = 1'b0;
  logic state_force_wr;
  logic [CSFP_STATE_W-1:0] state_force_val;
  logic card_type_force_wr;
  logic wide_bus_card_force;
  logic narrow_bus_card_force;
  logic power_cycle_event_set;
  logic detect_two_event_set;
  logic detect_one_event_set;
  logic status_change_event_set;
  logic sense_restart;
  logic clock_stop_allow;
  logic [CSFP_SUP_W-1:0] card_supply_select;
  logic [CSFP_SUP_W-1:0] program_supply_select;
  csfp_volt_e card_volt;
  csfp_volt_e program_volt;
  logic power_update_start;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 54;
  logic [31:0] d;
  logic cp;
  logic [7:0] ctl_m = 8'h00;
  logic [31:0] rq[$];
  logic [15:0] fq[$];
  logic [10:0] lq[$];
  logic [6:0] vq[$];
  logic rd1 = 1'b0;
  logic fw1 = 1'b0;
  logic cw1 = 1'b0;
  logic cw2 = 1'b0;
  logic [15:0] pv;
  logic [10:0] lv;
  logic [6:0] vv;

  always #20 ref_clk = ~ref_clk;

  csfp_top uut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .legacy_power_control_wr(legacy_power_control_wr),
    .legacy_vcc_wdata(legacy_vcc_wdata), .legacy_vpp_wdata(legacy_vpp_wdata),
    .legacy_vcc_rdata(legacy_vcc_rdata), .legacy_vpp_rdata(legacy_vpp_rdata),
    .card_present(card_present), .state_force_wr(state_force_wr),
    .state_force_val(state_force_val), .card_type_force_wr(card_type_force_wr),
    .wide_bus_card_force(wide_bus_card_force), .narrow_bus_card_force(narrow_bus_card_force),
    .power_cycle_event_set(power_cycle_event_set), .detect_two_event_set(detect_two_event_set),
    .detect_one_event_set(detect_one_event_set),
    .status_change_event_set(status_change_event_set), .sense_restart(sense_restart),
    .clock_stop_allow(clock_stop_allow), .card_supply_select(card_supply_select),
    .program_supply_select(program_supply_select), .card_volt(card_volt),
    .program_volt(program_volt), .power_update_start(power_update_start)
  );

  // Held override values only mean something while their write strobe is up
  assign pv = {sense_restart, state_force_wr, state_force_val & {CSFP_STATE_W{state_force_wr}},
    card_type_force_wr,
    wide_bus_card_force & card_type_force_wr, narrow_bus_card_force & card_type_force_wr,
    power_cycle_event_set, detect_two_event_set, detect_one_event_set, status_change_event_set};
  assign lv = {clock_stop_allow, card_supply_select, program_supply_select,
    legacy_vcc_rdata, legacy_vpp_rdata};
  assign vv = {card_volt, program_volt, power_update_start};

  function automatic logic [2:0] dec(input logic [2:0] c, input logic vpp);
    case (c)
      3'h0, 3'h2, 3'h3, 3'h4, 3'h5: dec = c;
      3'h1: dec = vpp ? 3'h1 : 3'h7;
      default: dec = 3'h7;
    endcase
  endfunction

  // Expected selects, volts and update pulse for a new control value
  task automatic ctl_upd(input logic [7:0] nv);
    lq.push_back({nv[7], nv[6:4], nv[2:0], nv[5:4], nv[1:0]});
    vq.push_back({dec(nv[6:4], 1'b0), dec(nv[2:0], 1'b1), nv[6:4] != ctl_m[6:4] ||
      nv[2:0] != ctl_m[2:0]});
    ctl_m = nv;
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] dt);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= dt;
    legacy_power_control_wr <= 1'b0;
    card_present <= cp;
    if (w && a == CSFP_OFS_CTRL)
      ctl_upd({dt[7:4], 1'b0, dt[2:0]});
    if (w && a == CSFP_OFS_FORCE)
      fq.push_back({dt[14], 1'b1, dt[13:7], ~cp, dt[5] & ~cp, dt[4] & ~cp, dt[3:0]});
    if (!w)
      rq.push_back(a == CSFP_OFS_CTRL ? {24'h00_0000, ctl_m} : 32'h0000_0000);
  endtask

  task automatic leg(input logic [1:0] c, input logic [1:0] p);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    legacy_power_control_wr <= 1'b1;
    legacy_vcc_wdata <= c;
    legacy_vpp_wdata <= p;
    ctl_upd({ctl_m[7:6], c, 1'b0, ctl_m[2], p});
  endtask

  task automatic idle();
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    legacy_power_control_wr <= 1'b0;
  endtask

  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Sampled mid-cycle so every registered answer has settled
  always @(negedge ref_clk)
  begin
    if (nrst)
    begin
      if (rd1)
        `CHK(reg_rdata, rq.pop_front(), "read data")
      else
        `CHK(reg_rdata, 32'h0000_0000, "idle read data")
      if (fw1)
        `CHK(pv, fq.pop_front(), "force effects")
      else
        `CHK(pv, 16'h0000, "quiet force outputs")
      if (cw1)
        `CHK(lv, lq.pop_front(), "control fields")
      if (cw2)
        `CHK(vv, vq.pop_front(), "supply decode")
      else
        `CHK(power_update_start, 1'b0, "spurious update")
    end
    cw2 = cw1;
    rd1 = reg_rd;
    fw1 = reg_wr && reg_addr == CSFP_OFS_FORCE;
    cw1 = (reg_wr && reg_addr == CSFP_OFS_CTRL) || legacy_power_control_wr;
  end

  // Whole run is about eighty cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end

  initial
  begin
    cp = 1'b0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    bus(0, CSFP_OFS_CTRL, 32'h0000_0000);
    bus(0, CSFP_OFS_FORCE, 32'h0000_0000);
    leg(2'h0, 2'h0);
    idle();
    $display("Test reset values done");
    // Every code of both supply fields; reserved bits stay zero as software must
    for (int i = 0; i < 16; i++)
    begin
      d = $random(seed) & 32'h0000_00f7;
      d[6:4] = i[2:0];
      d[2:0] = 3'(i * 3);
      bus(1, CSFP_OFS_CTRL, d);
      bus(0, CSFP_OFS_CTRL, 32'h0000_0000);
    end
    bus(1, CSFP_OFS_CTRL, d);
    bus(1, CSFP_OFS_CTRL, d ^ 32'h0000_0080);
    $display("Test control register done");
    for (int i = 0; i < 14; i++)
    begin
      d = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'hffff_ffff : $random(seed);
      // Reserved bits 31:15 and 6 stay zero
      d = d & 32'h0000_7fbf;
      cp = (i < 2) ? i[0] : 1'($random(seed));
      bus(1, CSFP_OFS_FORCE, d);
    end
    cp = 1'b0;
    bus(0, CSFP_OFS_FORCE, 32'h0000_0000);
    $display("Test force events done");
    for (int i = 0; i < 6; i++)
    begin
      d = $random(seed);
      leg(d[1:0], d[3:2]);
      if (i == 2)
        leg(d[1:0], d[3:2]);
    end
    // Register write beats a legacy write in the same cycle
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= CSFP_OFS_CTRL;
    reg_wdata <= 32'h0000_0035;
    legacy_power_control_wr <= 1'b1;
    legacy_vcc_wdata <= 2'h2;
    ctl_upd(8'h35);
    bus(0, CSFP_OFS_CTRL, 32'h0000_0000);
    $display("Test legacy view done");
    bus(1, 12'h014, $random(seed));
    bus(0, 12'h014, 32'h0000_0000);
    bus(0, 12'h00d, 32'h0000_0000);
    bus(0, CSFP_OFS_CTRL, 32'h0000_0000);
    idle();
    repeat (4) @(posedge ref_clk);
    $display("Test unmapped addresses done");
    close_out();
  end
endmodule
